// ===== sst_consts.svh
`ifndef SST_CONSTS_SVH
`define SST_CONSTS_SVH

// ****************************************
// Sizes
// ****************************************
`define SST_UNITS 8
`define SST_SIDES 2
`define SST_ADDR_W 4
`define SST_DATA_W 32
`define SST_EVENTS 2

// ****************************************
// Register offsets
// ****************************************
`define SST_OFF_CSW 4'h0
`define SST_OFF_UNITS 4'h4
`define SST_OFF_IRQ_STATUS 4'h8
`define SST_OFF_IRQ_MASK 4'hC

// ****************************************
// Field positions and unit map
// ****************************************
`define SST_CSW_SAT_BIT 0
`define SST_EV_SAT_BIT 0
`define SST_EV_DUAL_BIT 1
`define SST_M_UNIT_A 2
`define SST_M_UNIT_B 6

// ****************************************
// Reset values and responses
// ****************************************
`define SST_RST_UNITS 8'h00
`define SST_RST_EVENTS 2'h0
`define SST_RESP_OKAY 2'h0
`define SST_RESP_SLVERR 2'h2

`endif

// ===== sst_pkg.sv
`include "sst_consts.svh"

package sst_pkg;
   typedef logic [`SST_UNITS-1:0] sst_unit_vec_t;
   typedef logic [`SST_SIDES-1:0] sst_side_vec_t;
   typedef logic [`SST_EVENTS-1:0] sst_event_vec_t;
   typedef logic [`SST_ADDR_W-1:0] sst_addr_t;
   typedef logic [`SST_DATA_W-1:0] sst_data_t;

   // Per-unit set condition from a long multiply result on that unit's side
   function automatic logic sst_long_hit(input int unit, input sst_side_vec_t lv,
                                         input sst_side_vec_t ls);
      logic hit;
      hit = 1'b0;
      if (unit == `SST_M_UNIT_A) begin
         hit = lv[0] & ls[0];
      end else if (unit == `SST_M_UNIT_B) begin
         hit = lv[1] & ls[1];
      end
      return hit;
   endfunction : sst_long_hit
endpackage : sst_pkg

// ===== sst_result_if.sv
interface sst_result_if;
   import sst_pkg::*;
   sst_unit_vec_t res_valid;
   sst_unit_vec_t res_sat;
   sst_side_vec_t mlong_valid;
   sst_side_vec_t mlong_sat;
   logic flag_we;
   sst_unit_vec_t flag_wdata;
   sst_unit_vec_t flags;

   modport core (
      output res_valid,
      output res_sat,
      output mlong_valid,
      output mlong_sat,
      output flag_we,
      output flag_wdata,
      input flags
   );

   modport tracker (
      input res_valid,
      input res_sat,
      input mlong_valid,
      input mlong_sat,
      input flag_we,
      input flag_wdata,
      output flags
   );
endinterface : sst_result_if

// ===== sst_unit_flags.sv
`include "sst_consts.svh"

module sst_unit_flags (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Results in, flags out
   sst_result_if.tracker res
);
   import sst_pkg::*;

   sst_unit_vec_t unit_set;
   sst_unit_vec_t next_flags;

   // ****************************************
   // Per-unit flags
   // ****************************************
   for (genvar i = 0; i < `SST_UNITS; i++) begin : g_unit
      // Both multiply results feed the flag, so a coincident short one cannot mask the long one
      assign unit_set[i] = (res.res_valid[i] & res.res_sat[i])
                           | sst_long_hit(i, res.mlong_valid, res.mlong_sat);
      // Set wins over a software write in the same cycle
      assign next_flags[i] = unit_set[i] | (res.flag_we ? res.flag_wdata[i] : res.flags[i]);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         res.flags <= `SST_RST_UNITS;
      end else begin
         res.flags <= next_flags;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   a_unit_set_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      (unit_set != '0) |=> ((res.flags & $past(unit_set)) == $past(unit_set)))
      else $error("unit saturation did not set its flag");
   a_unit_flag_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      (!res.flag_we && unit_set == '0) |=> $stable(res.flags))
      else $error("unit flags changed without cause");
   a_long_m_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      (res.mlong_valid[1] && res.mlong_sat[1]) |=> res.flags[`SST_M_UNIT_B])
      else $error("long multiply saturation lost on second side");
endmodule : sst_unit_flags

// ===== sst_saturation_tracker.sv
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`include "sst_consts.svh"

module sst_saturation_tracker (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire sst_pkg::sst_addr_t s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   // AXI4-Lite write data
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire sst_pkg::sst_data_t s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // AXI4-Lite write response
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // AXI4-Lite read address
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire sst_pkg::sst_addr_t s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   // AXI4-Lite read data
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output sst_pkg::sst_data_t s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // Functional unit results, one per unit per cycle
   input wire sst_pkg::sst_unit_vec_t res_valid,
   input wire sst_pkg::sst_unit_vec_t res_sat,
   // Long multiply results per side, landing beside the short ones
   input wire sst_pkg::sst_side_vec_t mlong_valid,
   input wire sst_pkg::sst_side_vec_t mlong_sat,
   // Status out
   output logic saturation_sticky_flag,
   output sst_pkg::sst_unit_vec_t per_unit_saturation_flags,
   output logic irq
);
   import sst_pkg::*;

   // ****************************************
   // Register selection
   // ****************************************
   function automatic logic [3:0] reg_sel(input sst_addr_t a);
      logic [3:0] s;
      s = 4'h0;
      unique case (a)
         `SST_OFF_CSW: s = 4'h1;
         `SST_OFF_UNITS: s = 4'h2;
         `SST_OFF_IRQ_STATUS: s = 4'h4;
         `SST_OFF_IRQ_MASK: s = 4'h8;
         default: s = 4'h0;
      endcase
      return s;
   endfunction : reg_sel

   sst_result_if res_bus ();

   sst_unit_flags u_flags (
      .aclk(aclk),
      .aresetn(aresetn),
      .res(res_bus.tracker)
   );

   // ****************************************
   // Write channel
   // ****************************************
   logic aw_got;
   logic w_got;
   sst_addr_t aw_addr;
   sst_data_t w_data;
   logic [3:0] w_strb;
   logic sticky;
   sst_event_vec_t irq_status;
   sst_event_vec_t irq_mask;

   wire aw_hs = s_axi_awvalid & s_axi_awready;
   wire w_hs = s_axi_wvalid & s_axi_wready;
   wire do_write = aw_got & w_got & ~s_axi_bvalid;
   wire [3:0] wsel = reg_sel(aw_addr);
   wire wlane0 = do_write & w_strb[0];
   wire csw_we = wlane0 & wsel[0];
   wire unit_we = wlane0 & wsel[1];
   wire mask_we = wlane0 & wsel[3];
   wire next_aw_got = (aw_got | aw_hs) & ~do_write;
   wire next_w_got = (w_got | w_hs) & ~do_write;
   wire next_bvalid = do_write | (s_axi_bvalid & ~s_axi_bready);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_addr <= '0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SST_RESP_OKAY;
      end else begin
         aw_got <= next_aw_got;
         w_got <= next_w_got;
         if (aw_hs) begin
            aw_addr <= s_axi_awaddr;
         end
         if (w_hs) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         s_axi_awready <= ~next_aw_got & ~next_bvalid;
         s_axi_wready <= ~next_w_got & ~next_bvalid;
         s_axi_bvalid <= next_bvalid;
         if (do_write) begin
            s_axi_bresp <= (wsel == 4'h0) ? `SST_RESP_SLVERR : `SST_RESP_OKAY;
         end
      end
   end

   // ****************************************
   // Read channel
   // ****************************************
   wire ar_hs = s_axi_arvalid & s_axi_arready;
   wire [3:0] rsel = reg_sel(s_axi_araddr);
   wire next_rvalid = ar_hs | (s_axi_rvalid & ~s_axi_rready);
   // Status is cleared by the read that returns it, so no event can slip between read and clear
   wire irq_rd_clr = ar_hs & rsel[2];
   wire [31:0] rd_mux = ({32{rsel[0]}} & (32'(sticky) << `SST_CSW_SAT_BIT))
                        | ({32{rsel[1]}} & 32'(res_bus.flags))
                        | ({32{rsel[2]}} & 32'(irq_status))
                        | ({32{rsel[3]}} & 32'(irq_mask));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `SST_RESP_OKAY;
      end else begin
         s_axi_arready <= ~next_rvalid;
         s_axi_rvalid <= next_rvalid;
         if (ar_hs) begin
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= (rsel == 4'h0) ? `SST_RESP_SLVERR : `SST_RESP_OKAY;
         end
      end
   end

   // ****************************************
   // Saturation tracking
   // ****************************************
   sst_unit_vec_t unit_set;
   for (genvar i = 0; i < `SST_UNITS; i++) begin : g_set
      assign unit_set[i] = (res_valid[i] & res_sat[i]) | sst_long_hit(i, mlong_valid, mlong_sat);
   end

   // Any unit, short or long result, feeds the one sticky flag
   wire sat_any = |unit_set;
   wire dual_m = |(mlong_valid & {res_valid[`SST_M_UNIT_B], res_valid[`SST_M_UNIT_A]});
   // A clean result never clears; only a software write does, and a new saturation beats it
   wire next_sticky = sat_any | (csw_we ? w_data[`SST_CSW_SAT_BIT] : sticky);

   // The unit flags see only their own write strobe, never the sticky flag write
   assign res_bus.res_valid = res_valid;
   assign res_bus.res_sat = res_sat;
   assign res_bus.mlong_valid = mlong_valid;
   assign res_bus.mlong_sat = mlong_sat;
   assign res_bus.flag_we = unit_we;
   assign res_bus.flag_wdata = w_data[`SST_UNITS-1:0];

   // ****************************************
   // Interrupts
   // ****************************************
   sst_event_vec_t ev;
   assign ev[`SST_EV_SAT_BIT] = sat_any;
   assign ev[`SST_EV_DUAL_BIT] = dual_m;
   wire [`SST_EVENTS-1:0] next_irq_status = ev | (irq_rd_clr ? `SST_RST_EVENTS : irq_status);
   wire [`SST_EVENTS-1:0] next_irq_mask = mask_we ? w_data[`SST_EVENTS-1:0] : irq_mask;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sticky <= 1'b0;
         irq_status <= `SST_RST_EVENTS;
         irq_mask <= `SST_RST_EVENTS;
         irq <= 1'b0;
      end else begin
         sticky <= next_sticky;
         irq_status <= next_irq_status;
         irq_mask <= next_irq_mask;
         irq <= |(next_irq_status & next_irq_mask);
      end
   end

   assign saturation_sticky_flag = sticky;
   assign per_unit_saturation_flags = res_bus.flags;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_sat_sets_sticky: assert property (sat_any |=> sticky)
      else $error("saturation did not set sticky flag");
   a_any_unit_sticky: assert property (
      (|(res_valid & res_sat)) && !csw_we |=> sticky ##1 sticky)
      else $error("parallel saturation lost");
   a_sticky_holds: assert property ((sticky && !csw_we) |=> sticky)
      else $error("sticky flag cleared without a write");
   a_sticky_no_spurious: assert property ((!sticky && !sat_any && !csw_we) |=> !sticky)
      else $error("sticky flag set without saturation");
   a_csw_keeps_units: assert property (
      (csw_we && !unit_we && unit_set == '0) |=> $stable(per_unit_saturation_flags))
      else $error("sticky write changed unit flags");
   a_units_keep_sticky: assert property (
      (unit_we && !csw_we && !sat_any) |=> (sticky == $past(sticky)))
      else $error("unit flag write changed sticky flag");
   a_dual_m_sticky: assert property (
      (dual_m && mlong_valid[0] && mlong_sat[0] && !csw_we) |=> sticky)
      else $error("short multiply result masked long saturation");
   a_write_response: assert property (do_write |=> s_axi_bvalid ##0 !s_axi_awready)
      else $error("write response missing");
   a_read_clears_irq: assert property ((irq_rd_clr && ev == '0) |=> irq_status == '0)
      else $error("status read did not clear events");
   a_irq_level: assert property (irq == |(irq_status & irq_mask))
      else $error("interrupt level out of step with status");

   c_dual_m_sat: cover property (dual_m && sat_any);
   c_sticky_cleared: cover property (sticky ##1 csw_we ##1 !sticky);
   c_irq_raised: cover property (!irq ##1 irq);
   c_set_beats_clear: cover property (irq_rd_clr && ev != '0);
endmodule : sst_saturation_tracker

// ===== tb.sv
`include "sst_consts.svh"

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import sst_pkg::*;

   // ****************************************
   // Stimulus and observed signals
   // ****************************************
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_awready;
   sst_addr_t s_axi_awaddr = 4'h0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_wready;
   sst_data_t s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_bvalid;
   logic s_axi_bready = 1'b0;
   logic [1:0] s_axi_bresp;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_arready;
   sst_addr_t s_axi_araddr = 4'h0;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'b0;
   sst_data_t s_axi_rdata;
   logic [1:0] s_axi_rresp;
   sst_unit_vec_t res_valid = 8'h00;
   sst_unit_vec_t res_sat = 8'h00;
   sst_side_vec_t mlong_valid = 2'h0;
   sst_side_vec_t mlong_sat = 2'h0;
   logic saturation_sticky_flag;
   sst_unit_vec_t per_unit_saturation_flags;
   logic irq;
   sst_data_t rq[$];
   logic [1:0] rrq[$];
   logic [1:0] bq[$];
   int failures = 0;
   int cmp_count = 0;

   always #12.5 aclk = ~aclk;

   sst_saturation_tracker sst_saturation_tracker_i (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .res_valid(res_valid), .res_sat(res_sat),
      .mlong_valid(mlong_valid), .mlong_sat(mlong_sat),
      .saturation_sticky_flag(saturation_sticky_flag),
      .per_unit_saturation_flags(per_unit_saturation_flags), .irq(irq)
   );

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic chk(input sst_data_t e, input sst_data_t g);
      cmp_count++;
      if (e !== g) begin
         failures++;
         $display("unexpected at %0t: expected %h got %h", $time, e, g);
      end
   endtask : chk

   task automatic finish_test();
      $display("comparisons %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : finish_test

   // Callers enter just after a rising edge; the master never assumes a latency
   task automatic wr(input sst_addr_t a, input sst_data_t d, input logic [1:0] r = 2'h0);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      bq.push_back(r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready === 1'b1) begin
            aw_done = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready === 1'b1) begin
            w_done = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rd(input sst_addr_t a, input sst_data_t d, input logic [1:0] r = 2'h0);
      rq.push_back(d);
      rrq.push_back(r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
   endtask : rd

   // One cycle of results, then the result lines go quiet again
   task automatic pulse(input sst_unit_vec_t v, input sst_unit_vec_t s,
                        input sst_side_vec_t lv, input sst_side_vec_t ls);
      res_valid <= v;
      res_sat <= s;
      mlong_valid <= lv;
      mlong_sat <= ls;
      @(posedge aclk);
      res_valid <= 8'h00;
      res_sat <= 8'h00;
      mlong_valid <= 2'h0;
      mlong_sat <= 2'h0;
      @(posedge aclk);
   endtask : pulse

   // ****************************************
   // Response monitor
   // ****************************************
   always @(posedge aclk) begin
      if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
         chk(rq.pop_front(), s_axi_rdata);
         chk({30'h0, rrq.pop_front()}, {30'h0, s_axi_rresp});
      end
      if (s_axi_bvalid === 1'b1 && s_axi_bready) begin
         chk({30'h0, bq.pop_front()}, {30'h0, s_axi_bresp});
      end
   end

   initial begin
      #(25ns * 20000);
      failures++;
      finish_test();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      sst_unit_vec_t v;
      sst_unit_vec_t s;
      logic any;
      int u;
      void'($urandom(76));
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(`SST_OFF_CSW, 32'h0);
      rd(`SST_OFF_UNITS, 32'h0);
      rd(`SST_OFF_IRQ_STATUS, 32'h0);
      rd(`SST_OFF_IRQ_MASK, 32'h0);
      for (int i = 0; i < 8; i++) begin
         pulse(8'h01 << i, 8'h01 << i, 2'h0, 2'h0);
         chk({24'h0, 8'h01 << i}, {24'h0, per_unit_saturation_flags});
         chk(32'h1, {31'h0, saturation_sticky_flag});
         rd(`SST_OFF_IRQ_STATUS, 32'h1);
         wr(`SST_OFF_CSW, 32'h0);
         rd(`SST_OFF_UNITS, {24'h0, 8'h01 << i});
         wr(`SST_OFF_UNITS, 32'h0);
      end
      rd(`SST_OFF_CSW, 32'h0);
      repeat (6) begin
         v = sst_unit_vec_t'($urandom);
         s = sst_unit_vec_t'($urandom);
         any = |(v & s);
         pulse(v, s, 2'h0, 2'h0);
         rd(`SST_OFF_IRQ_STATUS, {31'h0, any});
         pulse(v, 8'h00, 2'h0, 2'h0);
         rd(`SST_OFF_CSW, {31'h0, any});
         rd(`SST_OFF_UNITS, {24'h0, v & s});
         wr(`SST_OFF_UNITS, 32'h0);
         rd(`SST_OFF_CSW, {31'h0, any});
         wr(`SST_OFF_CSW, 32'h0);
      end
      // Every mix of short and long outcome on both multipliers
      for (int side = 0; side < 2; side++) begin
         u = (side == 0) ? `SST_M_UNIT_A : `SST_M_UNIT_B;
         for (int j = 0; j < 4; j++) begin
            any = (j != 0);
            pulse(8'h01 << u, sst_unit_vec_t'(j & 1) << u, 2'h1 << side,
                  sst_side_vec_t'(j >> 1) << side);
            rd(`SST_OFF_CSW, {31'h0, any});
            rd(`SST_OFF_UNITS, {24'h0, sst_unit_vec_t'(any) << u});
            rd(`SST_OFF_IRQ_STATUS, {30'h0, 1'b1, any});
            wr(`SST_OFF_CSW, 32'h0);
            wr(`SST_OFF_UNITS, 32'h0);
         end
      end
      // A write without the low byte lane must leave the sticky flag alone
      s_axi_wstrb <= 4'he;
      wr(`SST_OFF_CSW, 32'h1);
      s_axi_wstrb <= 4'hf;
      rd(`SST_OFF_CSW, 32'h0);
      rd(4'h2, 32'h0, 2'h2);
      wr(4'h6, 32'hffff_ffff, 2'h2);
      rd(`SST_OFF_CSW, 32'h0);
      rd(`SST_OFF_UNITS, 32'h0);
      // Interrupt raised, masked, unmasked, cleared by reading status
      wr(`SST_OFF_IRQ_MASK, 32'h3);
      rd(`SST_OFF_IRQ_MASK, 32'h3);
      chk(32'h0, {31'h0, irq});
      pulse(8'h10, 8'h10, 2'h0, 2'h0);
      chk(32'h1, {31'h0, irq});
      wr(`SST_OFF_IRQ_MASK, 32'h0);
      chk(32'h0, {31'h0, irq});
      wr(`SST_OFF_IRQ_MASK, 32'h1);
      chk(32'h1, {31'h0, irq});
      rd(`SST_OFF_IRQ_STATUS, 32'h1);
      chk(32'h0, {31'h0, irq});
      rd(`SST_OFF_CSW, 32'h1);
      finish_test();
   end
endmodule : tb
